/* rtl/epdws_defs.svh */
// Offsets, field positions, reset values and timing figures of the waveform store.
// Included by the waveform store modules; definitions only.
`ifndef EPDWS_DEFS_SVH
`define EPDWS_DEFS_SVH

// Waveform setting layout (byte indices)
`define EPDWS_WS_BYTES        233
`define EPDWS_LUT_FIRST       8'd0
`define EPDWS_LUT_LAST        8'd226
`define EPDWS_OFS_FRAME_RATE  8'd224
`define EPDWS_OFS_XON_LOW     8'd225
`define EPDWS_OFS_XON_HIGH    8'd226
`define EPDWS_OFS_POWER_OFF   8'd227
`define EPDWS_OFS_GATE_LEVEL  8'd228
`define EPDWS_OFS_SRC_FIRST   8'd229
`define EPDWS_OFS_SRC_LAST    8'd231
`define EPDWS_OFS_COM_LEVEL   8'd232
`define EPDWS_GROUP_BYTES     7
`define EPDWS_TC_GROUPS       3'd7
`define EPDWS_BW_GROUPS       3'd5
`define EPDWS_TC_TABLES       3'd4
`define EPDWS_BW_TABLES       3'd5
`define EPDWS_TC_TABLE_BYTES  56
`define EPDWS_BW_TABLE_BYTES  42
`define EPDWS_LSEL_MSB        7
`define EPDWS_LSEL_LSB        6
`define EPDWS_PLEN_MSB        5

// Host commands that address the setting
`define EPDWS_CMD_LUT         8'h32
`define EPDWS_CMD_POWER_OFF   8'h3f
`define EPDWS_CMD_GATE        8'h03
`define EPDWS_CMD_SOURCE      8'h04
`define EPDWS_CMD_COM         8'h2c

// Power-off options
`define EPDWS_POFF_DISCHARGE  8'h22
`define EPDWS_POFF_KEEP       8'h07
`define EPDWS_POFF_SCANS      6'd2

// Register map (byte addresses)
`define EPDWS_REG_CTRL        8'h00
`define EPDWS_REG_STATUS      8'h04
`define EPDWS_REG_CMD         8'h08
`define EPDWS_REG_DATA        8'h0c
`define EPDWS_REG_DRIVE       8'h10
`define EPDWS_CTRL_START      0
`define EPDWS_CTRL_BW         1
`define EPDWS_CTRL_RESET      32'h0000_0000

// Clock in Hz; frame rates in units of 0.5 Hz
`define EPDWS_CLK_HZ          50000000
`define EPDWS_HZ2_25          50
`define EPDWS_HZ2_37P5        75
`define EPDWS_HZ2_50          100
`define EPDWS_HZ2_62P5        125
`define EPDWS_HZ2_75          150
`define EPDWS_HZ2_87P5        175
`define EPDWS_HZ2_100         200
`define EPDWS_HZ2_112P5       225
`define EPDWS_HZ2_125         250

`endif

/* rtl/epdws_pkg.sv */
// Types shared by the waveform store modules.
// Assumes nothing beyond the constants header.
package epdws_pkg;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } epdws_axil_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } epdws_axil_rsp_type;

  typedef enum logic [2:0] {
    SEQ_IDLE    = 3'b000,
    SEQ_GROUP   = 3'b001,
    SEQ_PAIR    = 3'b010,
    SEQ_PHASE   = 3'b011,
    SEQ_OFFSCAN = 3'b100,
    SEQ_OFFSTEP = 3'b101
  } epdws_seq_type;

  typedef struct packed {
    logic            phaseActive;
    logic            gateAllOn;
    logic            gateScan;
    logic [4:0][1:0] levelSel;
    logic            comFloat;
    logic            pixelDischarge;
    logic            comDischarge;
    logic            hvDischarge;
    logic            gateLowFloat;
  } epdws_drive_type;

endpackage

/* rtl/epdws_frame_timer.sv */
// Frame tick generator: one-cycle pulse per display frame.
// Assumes a single clock of CLK_HZ and a frame rate code stable while enabled.
`timescale 1ns/1ps
`include "epdws_defs.svh"
module epdws_frame_timer #(
  parameter int CLK_HZ = `EPDWS_CLK_HZ
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       enable,
  input  wire logic [3:0] rateCode,
  output logic            tick
);
  localparam int P25   = CLK_HZ * 2 / `EPDWS_HZ2_25;
  localparam int P37   = CLK_HZ * 2 / `EPDWS_HZ2_37P5;
  localparam int P50   = CLK_HZ * 2 / `EPDWS_HZ2_50;
  localparam int P62   = CLK_HZ * 2 / `EPDWS_HZ2_62P5;
  localparam int P75   = CLK_HZ * 2 / `EPDWS_HZ2_75;
  localparam int P87   = CLK_HZ * 2 / `EPDWS_HZ2_87P5;
  localparam int P100  = CLK_HZ * 2 / `EPDWS_HZ2_100;
  localparam int P112  = CLK_HZ * 2 / `EPDWS_HZ2_112P5;
  localparam int P125  = CLK_HZ * 2 / `EPDWS_HZ2_125;

  if (CLK_HZ < `EPDWS_HZ2_125)
  begin : g_bad_clk
    $error("CLK_HZ too small for the fastest frame rate");
  end

  logic [31:0] period;
  logic [31:0] cnt_q;

  always_comb
  begin
    case (rateCode) // RULE_01
      4'h1:    period = 32'(P25);
      4'h2:    period = 32'(P50);
      4'h3:    period = 32'(P75);
      4'h4:    period = 32'(P100);
      4'h5:    period = 32'(P125);
      4'h9:    period = 32'(P37);
      4'ha:    period = 32'(P62);
      4'hb:    period = 32'(P87);
      4'hc:    period = 32'(P112);
      // Unlisted codes fall back to the slowest rate so a sequence never stalls
      default: period = 32'(P25);
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst || !enable)
      cnt_q <= 32'h0;
    else if (cnt_q >= period - 32'h1)
      cnt_q <= 32'h0;
    else
      cnt_q <= cnt_q + 32'h1;
  end

  assign tick = enable && (cnt_q >= period - 32'h1);
endmodule

/* rtl/epdws_axil_slave.sv */
// AXI4-Lite slave front end: turns bus transfers into register strobes.
// Assumes one write and one read in flight; register data is supplied combinationally.
`timescale 1ns/1ps
module epdws_axil_slave (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire epdws_pkg::epdws_axil_req_type axiReq,
  output epdws_pkg::epdws_axil_rsp_type    axiRsp,
  output logic                             wrStb,
  output logic [7:0]                       wrAddr,
  output logic [31:0]                      wrData,
  output logic [3:0]                       wrStrb,
  input  wire logic                        wrOk,
  output logic                             rdStb,
  output logic [7:0]                       rdAddr,
  input  wire logic [31:0]                 rdData,
  input  wire logic                        rdOk
);
  logic        awHave_q;
  logic        wHave_q;
  logic [7:0]  awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        bValid_q;
  logic [1:0]  bResp_q;
  logic        rValid_q;
  logic [31:0] rData_q;
  logic [1:0]  rResp_q;

  assign axiRsp.awready = !awHave_q && !bValid_q;
  assign axiRsp.wready  = !wHave_q && !bValid_q;
  assign axiRsp.arready = !rValid_q;
  assign axiRsp.bvalid  = bValid_q;
  assign axiRsp.bresp   = bResp_q;
  assign axiRsp.rvalid  = rValid_q;
  assign axiRsp.rdata   = rData_q;
  assign axiRsp.rresp   = rResp_q;

  // Address and data may arrive in either order; the strobe fires once both are held
  assign wrStb  = awHave_q && wHave_q && !bValid_q;
  assign wrAddr = awAddr_q;
  assign wrData = wData_q;
  assign wrStrb = wStrb_q;
  assign rdStb  = axiReq.arvalid && !rValid_q;
  assign rdAddr = axiReq.araddr;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      awHave_q <= 1'b0;
      wHave_q  <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q  <= 32'h0;
      wStrb_q  <= 4'h0;
      bValid_q <= 1'b0;
      bResp_q  <= 2'b00;
    end
    else
    begin
      if (axiReq.awvalid && axiRsp.awready)
      begin
        awHave_q <= 1'b1;
        awAddr_q <= axiReq.awaddr;
      end
      if (axiReq.wvalid && axiRsp.wready)
      begin
        wHave_q <= 1'b1;
        wData_q <= axiReq.wdata;
        wStrb_q <= axiReq.wstrb;
      end
      if (wrStb)
      begin
        awHave_q <= 1'b0;
        wHave_q  <= 1'b0;
        bValid_q <= 1'b1;
        bResp_q  <= wrOk ? 2'b00 : 2'b10;
      end
      else if (bValid_q && axiReq.bready)
        bValid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rValid_q <= 1'b0;
      rData_q  <= 32'h0;
      rResp_q  <= 2'b00;
    end
    else if (rdStb)
    begin
      rValid_q <= 1'b1;
      rData_q  <= rdOk ? rdData : 32'h0;
      rResp_q  <= rdOk ? 2'b00 : 2'b10;
    end
    else if (rValid_q && axiReq.rready)
      rValid_q <= 1'b0;
  end
endmodule

/* rtl/epdws_waveform_store.sv */
// Waveform setting store and drive sequencer for an e-paper driver.
// Assumes OTP bytes arrive as single-cycle writes and that software drives AXI4-Lite.
//
// Overview of operation
// RULE_01 - Frame rate code picks the frame period
// RULE_02 - Flag clear: normal gate scan in pair
// RULE_03 - Flag set: all gates high in pair
// RULE_04 - Option 0x22: two scans, then staged discharge
// RULE_05 - Option 0x07: no scan, float and discharge
// RULE_06 - Host waits for discharge after option 0x07
// RULE_07 - Store holds one 233-byte setting
// RULE_08 - Bytes 0..226 written by command 0x32
// RULE_09 - Byte 227 is power-off option, command 0x3F
// RULE_10 - Byte 228 is gate level, command 0x03
// RULE_11 - Bytes 229..231 source levels, command 0x04
// RULE_12 - Byte 232 common level, command 0x2C
// RULE_13 - Loadable from OTP or host commands
// RULE_14 - Latest write wins over earlier loads; a host byte drops an OTP byte written in the same cycle
// RULE_15 - Three-colour: four tables of eight groups
// RULE_16 - Black/white: five tables of six groups
// RULE_17 - Bytes 224..226: frame rate, gate-on flags
// RULE_18 - Two-bit level select chooses drive levels
// RULE_19 - Phase length in frames, zero skips
// RULE_20 - Group repeat count, zero skips group
// RULE_21 - State repeat count, zero skips pair
// RULE_22 - Groups ascend, AB then CD, power-off last
`timescale 1ns/1ps
`include "epdws_defs.svh"
module epdws_waveform_store #(
  parameter int CLK_HZ = `EPDWS_CLK_HZ
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire epdws_pkg::epdws_axil_req_type axiReq,
  output epdws_pkg::epdws_axil_rsp_type      axiRsp,
  input  wire logic                          otpWrEn,
  input  wire logic [7:0]                    otpAddr,
  input  wire logic [7:0]                    otpData,
  output epdws_pkg::epdws_drive_type         drive,
  output logic                               frameTick,
  output logic                               busy
);
  if (CLK_HZ < `EPDWS_HZ2_125)
  begin : g_bad_clk
    $error("CLK_HZ too small for the fastest frame rate");
  end

  logic [7:0]  wsMem_q [0:`EPDWS_WS_BYTES-1];
  logic        wrStb;
  logic [7:0]  wrAddr;
  logic [31:0] wrData;
  logic [3:0]  wrStrb;
  logic        wrOk;
  logic        rdStb;
  logic [7:0]  rdAddr;
  logic [31:0] rdData;
  logic        rdOk;
  logic        bwMode_q;
  logic [7:0]  ptr_q;
  logic [7:0]  ptrEnd_q;
  logic        overrun_q;
  logic        hostByteWr;
  logic        startReq;

  epdws_axil_slave u_bus (
    .clk    (clk),
    .rst    (rst),
    .axiReq (axiReq),
    .axiRsp (axiRsp),
    .wrStb  (wrStb),
    .wrAddr (wrAddr),
    .wrData (wrData),
    .wrStrb (wrStrb),
    .wrOk   (wrOk),
    .rdStb  (rdStb),
    .rdAddr (rdAddr),
    .rdData (rdData),
    .rdOk   (rdOk)
  );

  assign wrOk = (wrAddr == `EPDWS_REG_CTRL) || (wrAddr == `EPDWS_REG_CMD) || (wrAddr == `EPDWS_REG_DATA);
  assign hostByteWr = wrStb && (wrAddr == `EPDWS_REG_DATA) && wrStrb[0] && (ptr_q <= ptrEnd_q);
  assign startReq   = wrStb && (wrAddr == `EPDWS_REG_CTRL) && wrStrb[0] && wrData[`EPDWS_CTRL_START];

  // Command selects a window of the setting; data bytes fill it in order
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ptr_q     <= `EPDWS_LUT_FIRST;
      ptrEnd_q  <= `EPDWS_LUT_LAST;
      overrun_q <= 1'b0;
    end
    else if (wrStb && wrAddr == `EPDWS_REG_CMD && wrStrb[0])
    begin
      overrun_q <= 1'b0;
      case (wrData[7:0])
        `EPDWS_CMD_LUT:       begin ptr_q <= `EPDWS_LUT_FIRST;      ptrEnd_q <= `EPDWS_LUT_LAST;      end // RULE_08
        `EPDWS_CMD_POWER_OFF: begin ptr_q <= `EPDWS_OFS_POWER_OFF;  ptrEnd_q <= `EPDWS_OFS_POWER_OFF;  end // RULE_09
        `EPDWS_CMD_GATE:      begin ptr_q <= `EPDWS_OFS_GATE_LEVEL; ptrEnd_q <= `EPDWS_OFS_GATE_LEVEL; end // RULE_10
        `EPDWS_CMD_SOURCE:    begin ptr_q <= `EPDWS_OFS_SRC_FIRST;  ptrEnd_q <= `EPDWS_OFS_SRC_LAST;   end // RULE_11
        `EPDWS_CMD_COM:       begin ptr_q <= `EPDWS_OFS_COM_LEVEL;  ptrEnd_q <= `EPDWS_OFS_COM_LEVEL;  end // RULE_12
        default:              begin ptr_q <= 8'hff;                 ptrEnd_q <= 8'h00;                 end
      endcase
    end
    else if (hostByteWr)
      ptr_q <= ptr_q + 8'h01;
    else if (wrStb && wrAddr == `EPDWS_REG_DATA && wrStrb[0])
      overrun_q <= 1'b1;
  end

  // One shared store; the later write is what the sequencer plays, and a host byte drops an OTP byte in the same cycle
  always_ff @(posedge clk)
  begin
    if (hostByteWr)
      wsMem_q[ptr_q] <= wrData[7:0]; // RULE_07 RULE_13 RULE_14
    else if (otpWrEn && otpAddr < 8'(`EPDWS_WS_BYTES))
      wsMem_q[otpAddr] <= otpData; // RULE_13
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      bwMode_q <= 1'(`EPDWS_CTRL_RESET >> `EPDWS_CTRL_BW);
    else if (wrStb && wrAddr == `EPDWS_REG_CTRL && wrStrb[0] && !busy)
      bwMode_q <= wrData[`EPDWS_CTRL_BW];
  end

  // Sequencer
  epdws_pkg::epdws_seq_type state_q;
  logic [2:0] grp_q;
  logic [7:0] rpCnt_q;
  logic       pair_q;
  logic [7:0] srCnt_q;
  logic       ph_q;
  logic [5:0] frm_q;
  logic       offStep_q;
  logic       comFloatHold_q;
  logic       gateLowFloatHold_q;
  logic [2:0] lastGrp;
  logic [2:0] nTables;
  logic [7:0] grpBase;
  logic [7:0] groupRepeat;
  logic [7:0] stateRepeat;
  logic [7:0] phaseByte;
  logic [5:0] phaseLength;
  logic [7:0] xonByte;
  logic       allGateOn;
  logic [7:0] powerOff;
  logic       lastGroup;

  function automatic logic [7:0] lutAddr(input logic bw, input logic [2:0] tbl, input logic [2:0] grp,
                                         input logic [2:0] ofs);
    int a;
    a = int'(tbl) * (bw ? `EPDWS_BW_TABLE_BYTES : `EPDWS_TC_TABLE_BYTES) + int'(grp) * `EPDWS_GROUP_BYTES + int'(ofs);
    return 8'(a);
  endfunction

  assign lastGrp     = bwMode_q ? `EPDWS_BW_GROUPS : `EPDWS_TC_GROUPS; // RULE_15 RULE_16
  assign nTables     = bwMode_q ? `EPDWS_BW_TABLES : `EPDWS_TC_TABLES;
  assign grpBase     = lutAddr(bwMode_q, 3'd0, grp_q, 3'd0);
  assign groupRepeat = wsMem_q[grpBase];
  assign stateRepeat = wsMem_q[grpBase + 8'd5 + {7'h00, pair_q}];
  assign phaseByte   = wsMem_q[grpBase + 8'd1 + {6'h00, pair_q, ph_q}];
  assign phaseLength = phaseByte[`EPDWS_PLEN_MSB:0];
  assign xonByte     = grp_q[2] ? wsMem_q[`EPDWS_OFS_XON_HIGH] : wsMem_q[`EPDWS_OFS_XON_LOW]; // RULE_17
  assign allGateOn   = xonByte[{grp_q[1:0], pair_q}];
  assign powerOff    = wsMem_q[`EPDWS_OFS_POWER_OFF];
  assign lastGroup   = (grp_q == lastGrp);
  assign busy        = (state_q != epdws_pkg::SEQ_IDLE);

  epdws_frame_timer #(
    .CLK_HZ (CLK_HZ)
  ) u_timer (
    .clk      (clk),
    .rst      (rst),
    .enable   (busy),
    .rateCode (wsMem_q[`EPDWS_OFS_FRAME_RATE][3:0]), // RULE_01 RULE_17
    .tick     (frameTick)
  );

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q   <= epdws_pkg::SEQ_IDLE;
      grp_q     <= 3'd0;
      rpCnt_q   <= 8'h00;
      pair_q    <= 1'b0;
      srCnt_q   <= 8'h00;
      ph_q      <= 1'b0;
      frm_q     <= 6'd0;
      offStep_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        epdws_pkg::SEQ_IDLE:
          if (startReq)
          begin
            grp_q   <= 3'd0;
            rpCnt_q <= 8'h00;
            state_q <= epdws_pkg::SEQ_GROUP;
          end
        epdws_pkg::SEQ_GROUP:
          if (rpCnt_q >= groupRepeat) // RULE_20
          begin
            rpCnt_q <= 8'h00;
            if (lastGroup) // RULE_22
            begin
              frm_q     <= 6'd0;
              offStep_q <= 1'b0;
              if (powerOff == `EPDWS_POFF_DISCHARGE)
                state_q <= epdws_pkg::SEQ_OFFSCAN; // RULE_04
              else if (powerOff == `EPDWS_POFF_KEEP)
                state_q <= epdws_pkg::SEQ_OFFSTEP; // RULE_05
              else
                state_q <= epdws_pkg::SEQ_IDLE;
            end
            else
              grp_q <= grp_q + 3'd1;
          end
          else
          begin
            pair_q  <= 1'b0;
            srCnt_q <= 8'h00;
            state_q <= epdws_pkg::SEQ_PAIR;
          end
        epdws_pkg::SEQ_PAIR:
          if (srCnt_q >= stateRepeat) // RULE_21
          begin
            srCnt_q <= 8'h00;
            if (pair_q)
            begin
              rpCnt_q <= rpCnt_q + 8'h01;
              state_q <= epdws_pkg::SEQ_GROUP;
            end
            else
              pair_q <= 1'b1; // RULE_22
          end
          else
          begin
            ph_q    <= 1'b0;
            frm_q   <= 6'd0;
            state_q <= epdws_pkg::SEQ_PHASE;
          end
        epdws_pkg::SEQ_PHASE:
          if (frm_q >= phaseLength) // RULE_19
          begin
            frm_q <= 6'd0;
            if (ph_q)
            begin
              srCnt_q <= srCnt_q + 8'h01;
              state_q <= epdws_pkg::SEQ_PAIR;
            end
            else
              ph_q <= 1'b1;
          end
          else if (frameTick)
            frm_q <= frm_q + 6'd1;
        epdws_pkg::SEQ_OFFSCAN:
          if (frm_q >= `EPDWS_POFF_SCANS) // RULE_04
            state_q <= epdws_pkg::SEQ_OFFSTEP;
          else if (frameTick)
            frm_q <= frm_q + 6'd1;
        epdws_pkg::SEQ_OFFSTEP:
          // Each discharge stage lasts one frame
          if (frameTick)
          begin
            offStep_q <= 1'b1;
            if (offStep_q)
              state_q <= epdws_pkg::SEQ_IDLE;
          end
        default:
          state_q <= epdws_pkg::SEQ_IDLE;
      endcase
    end
  end

  // Floating nodes persist after a keep-style power-off until the next update
  always_ff @(posedge clk)
  begin
    if (rst || startReq)
    begin
      comFloatHold_q     <= 1'b0;
      gateLowFloatHold_q <= 1'b0;
    end
    else if (state_q == epdws_pkg::SEQ_OFFSTEP && powerOff == `EPDWS_POFF_KEEP)
    begin
      comFloatHold_q     <= 1'b1; // RULE_05
      gateLowFloatHold_q <= offStep_q;
    end
  end

  logic inPhase;
  assign inPhase = (state_q == epdws_pkg::SEQ_PHASE) && (frm_q < phaseLength);

  always_ff @(posedge clk)
  begin
    if (rst)
      drive <= '0;
    else
    begin
      drive.phaseActive <= inPhase;
      drive.gateAllOn   <= inPhase && allGateOn; // RULE_03
      drive.gateScan    <= (inPhase && !allGateOn) || (state_q == epdws_pkg::SEQ_OFFSCAN); // RULE_02
      for (int t = 0; t < 5; t++)
        drive.levelSel[t] <= (inPhase && 3'(t) < nTables) ?
          wsMem_q[lutAddr(bwMode_q, 3'(t), grp_q, {1'b0, pair_q, ph_q} + 3'd1)][`EPDWS_LSEL_MSB:`EPDWS_LSEL_LSB] :
          2'b00; // RULE_18
      drive.comFloat       <= (inPhase && phaseByte[`EPDWS_LSEL_MSB:`EPDWS_LSEL_LSB] == 2'b11) || comFloatHold_q ||
                              (state_q == epdws_pkg::SEQ_OFFSTEP && powerOff == `EPDWS_POFF_KEEP); // RULE_18 RULE_05
      drive.pixelDischarge <= (state_q == epdws_pkg::SEQ_OFFSCAN); // RULE_04
      drive.comDischarge   <= (state_q == epdws_pkg::SEQ_OFFSTEP) && !offStep_q && (powerOff == `EPDWS_POFF_DISCHARGE);
      drive.hvDischarge    <= (state_q == epdws_pkg::SEQ_OFFSTEP) && (offStep_q || powerOff == `EPDWS_POFF_KEEP);
      drive.gateLowFloat   <= gateLowFloatHold_q ||
                              ((state_q == epdws_pkg::SEQ_OFFSTEP) && offStep_q && powerOff == `EPDWS_POFF_KEEP);
    end
  end

  // Register read side
  always_comb
  begin
    rdOk   = 1'b1;
    rdData = 32'h0;
    case (rdAddr)
      `EPDWS_REG_CTRL:   rdData = {30'h0, bwMode_q, 1'b0};
      `EPDWS_REG_STATUS: rdData = {20'h0, grp_q, state_q, 4'h0, overrun_q, busy};
      `EPDWS_REG_CMD:    rdData = {16'h0, ptrEnd_q, ptr_q};
      `EPDWS_REG_DATA:   rdData = (ptr_q < 8'(`EPDWS_WS_BYTES)) ? {24'h0, wsMem_q[ptr_q]} : 32'h0;
      `EPDWS_REG_DRIVE:  rdData = {14'h0, drive};
      default:           rdOk   = 1'b0;
    endcase
  end

  // Checks
  sequence s_poff_scan;
    state_q == epdws_pkg::SEQ_OFFSCAN && frm_q == `EPDWS_POFF_SCANS;
  endsequence

  chk_zero_group_skip: assert property (@(posedge clk) disable iff (rst) // RULE_20
    state_q == epdws_pkg::SEQ_GROUP && groupRepeat == 8'h00 |=> state_q != epdws_pkg::SEQ_PAIR)
    else $error("group with zero repeat was entered");
  chk_zero_pair_skip: assert property (@(posedge clk) disable iff (rst) // RULE_21
    state_q == epdws_pkg::SEQ_PAIR && stateRepeat == 8'h00 |=> state_q != epdws_pkg::SEQ_PHASE)
    else $error("pair with zero state repeat was played");
  chk_phase_length: assert property (@(posedge clk) disable iff (rst) // RULE_19
    state_q == epdws_pkg::SEQ_PHASE |-> frm_q <= phaseLength)
    else $error("phase ran beyond its length");
  chk_gate_all_on: assert property (@(posedge clk) disable iff (rst) // RULE_03
    inPhase && allGateOn |=> drive.gateAllOn && !drive.gateScan)
    else $error("all-gate-on pair did not hold gates high");
  chk_gate_scan: assert property (@(posedge clk) disable iff (rst) // RULE_02
    inPhase && !allGateOn |=> drive.gateScan && !drive.gateAllOn)
    else $error("normal pair did not scan");
  chk_discharge_scans: assert property (@(posedge clk) disable iff (rst) // RULE_04
    s_poff_scan |=> state_q == epdws_pkg::SEQ_OFFSTEP ##1 drive.comDischarge)
    else $error("discharge sequence did not follow two scan frames");
  chk_keep_no_scan: assert property (@(posedge clk) disable iff (rst) // RULE_05
    state_q == epdws_pkg::SEQ_OFFSTEP && powerOff == `EPDWS_POFF_KEEP |=> !drive.pixelDischarge && drive.comFloat)
    else $error("keep option scanned or left common driven");
  chk_host_write: assert property (@(posedge clk) disable iff (rst) // RULE_14
    hostByteWr |=> wsMem_q[$past(ptr_q)] == $past(wrData[7:0]))
    else $error("host byte not stored over earlier content");
  chk_order_ab_cd: assert property (@(posedge clk) disable iff (rst) // RULE_22
    state_q == epdws_pkg::SEQ_PAIR && pair_q && srCnt_q >= stateRepeat |=>
      state_q == epdws_pkg::SEQ_GROUP && rpCnt_q == $past(rpCnt_q) + 8'h01)
    else $error("group pass did not close after the CD pair");
endmodule

/* test/epdws_host_model.sv */
// Host model: AXI4-Lite master that reaches the waveform store registers.
// Assumes a single clock; only the bench timeout ends a wait.
`timescale 1ns/1ps
module epdws_host_model (
  input  wire logic                          clk,
  output epdws_pkg::epdws_axil_req_type      req,
  input  wire epdws_pkg::epdws_axil_rsp_type rsp
);
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= {1'b1, a, 1'b1, d, 4'hf, 1'b1, 1'b0, 8'h00, 1'b0};
    do
    begin
      @(posedge clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    req <= {1'b0, 8'h00, 1'b0, 32'h0, 4'h0, 1'b0, 1'b1, a, 1'b1};
    do
    begin
      @(posedge clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask
endmodule

/* test/epd_waveform_setting_table_tb.sv */
// Self-checking bench for the waveform store and sequencer.
// Assumes the host model above; frame clock shortened through CLK_HZ.
`timescale 1ns/1ps
module epd_waveform_setting_table_tb;
  logic                          clk = 1'b0;
  logic                          rst = 1'b1;
  logic                          otpWrEn = 1'b0;
  logic [7:0]                    otpAddr = 8'h00;
  logic [7:0]                    otpData = 8'h00;
  epdws_pkg::epdws_axil_req_type axiReq;
  epdws_pkg::epdws_axil_rsp_type axiRsp;
  epdws_pkg::epdws_drive_type    drive;
  logic                          frameTick;
  logic                          busy;
  int                            numErrors = 0;
  int                            totalChecks = 0;
  logic [31:0]                   rdat;
  logic [1:0]                    rresp;
  logic [7:0]                    ws [0:226];
  logic [7:0]                    cmds [5] = '{8'h32, 8'h3f, 8'h03, 8'h04, 8'h2c};
  logic [15:0]                   win [5] = '{16'he200, 16'he3e3, 16'he4e4, 16'he7e5, 16'he8e8};
  logic [7:0]                    g0 [7] = '{8'h01, 8'h01, 8'h02, 8'h03, 8'h00, 8'h01, 8'h02};
  always #10 clk = ~clk;
  epdws_waveform_store #(.CLK_HZ(250)) dut (.clk(clk), .rst(rst), .axiReq(axiReq), .axiRsp(axiRsp),
    .otpWrEn(otpWrEn), .otpAddr(otpAddr), .otpData(otpData), .drive(drive), .frameTick(frameTick), .busy(busy));
  epdws_host_model host (.clk(clk), .req(axiReq), .rsp(axiRsp));
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finishTest();
    if (numErrors == 0 && totalChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Clock cycles per frame at the shortened bench clock of 250 Hz
  function automatic int frameCycles(int halfHz);
    return 250 * 2 / halfHz;
  endfunction
  // Loads the table, sets the off option, starts and counts phase, scan and hv discharge frames until idle
  task automatic runUpdate(logic [7:0] opt, logic [31:0] ctrl, int expPer);
    int n;
    int lastTick = -1;
    int per = 0;
    int phFr = 0;
    int scanFr = 0;
    int hvFr = 0;
    logic tickPrev = 1'b0;
    logic gOn = 1'b0;
    logic gScan = 1'b0;
    logic pDis = 1'b0;
    host.wr(8'h08, 32'h32);
    for (int i = 0; i < 227; i++) host.wr(8'h0c, {24'h0, ws[i]});
    host.wr(8'h08, 32'h3f);
    host.wr(8'h0c, {24'h0, opt});
    host.wr(8'h00, ctrl);
    // Host waits for full discharge before its next access
    for (n = 0; n < 5000 && (n < 3 || busy); n++)
    begin
      @(negedge clk);
      // Drive lags the sequencer by a cycle, so it pairs with the previous tick
      phFr += int'(drive.phaseActive && tickPrev);
      scanFr += int'(drive.pixelDischarge && tickPrev);
      hvFr += int'(drive.hvDischarge && tickPrev);
      if (frameTick)
      begin
        if (lastTick >= 0)
          per = n - lastTick;
        lastTick = n;
      end
      tickPrev = frameTick;
      gOn |= drive.gateAllOn;
      gScan |= drive.gateScan && drive.phaseActive;
      pDis |= drive.pixelDischarge;
    end
    check("framePeriod", per, expPer);
    check("phaseFrames", phFr, 9);
    check("scanFrames", scanFr, (opt == 8'h22) ? 2 : 0);
    check("hvFrames", hvFr, (opt == 8'h22) ? 1 : 2);
    check("allGateOn", gOn, 1);
    check("gateScan", gScan, 1);
    check("pixelDischarge", pDis, opt == 8'h22);
    check("comFloat", drive.comFloat, opt == 8'h07);
  endtask
  initial
  begin
    void'($urandom(7));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    host.rd(8'h00, rdat, rresp);
    check("ctrl", rdat, 32'h0);
    for (int k = 0; k < 5; k++)
    begin
      host.wr(8'h08, {24'h0, cmds[k]});
      host.rd(8'h08, rdat, rresp);
      check("window", rdat[15:0], win[k]);
    end
    @(posedge clk);
    otpWrEn <= 1'b1;
    otpAddr <= 8'd227;
    otpData <= 8'h07;
    @(posedge clk);
    otpWrEn <= 1'b0;
    host.wr(8'h08, 32'h3f);
    host.rd(8'h0c, rdat, rresp);
    check("otpByte", rdat, 32'h07);
    host.wr(8'h0c, 32'h22);
    host.wr(8'h08, 32'h3f);
    host.rd(8'h0c, rdat, rresp);
    check("hostByte", rdat, 32'h22);
    host.rd(8'h40, rdat, rresp);
    check("unmapped", rresp, 2'b10);
    // Group 0: AB 3 frames once, CD 3 frames twice; group 1 has zero state repeats; rest skipped
    for (int i = 0; i < 227; i++)
    begin
      ws[i] = 8'($urandom);
      if (i < 7)
        ws[i] = (i inside {[1:4]}) ? {ws[i][7:6], g0[i][5:0]} : g0[i];
      else if (i < 56 && i % 7 == 0)
        ws[i] = 8'h00;
    end
    ws[224] = 8'h05;
    ws[225] = 8'h01;
    ws[226] = 8'h00;
    ws[7] = 8'h01;
    ws[12] = 8'h00;
    ws[13] = 8'h00;
    runUpdate(8'h22, 32'h1, frameCycles(250));
    ws[224] = 8'h01;
    runUpdate(8'h07, 32'h3, frameCycles(50));
    finishTest();
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    numErrors++;
    finishTest();
  end
endmodule
